/* File: rtl/mru_regs.sv */
`timescale 1ns/1ps
`include "mru_params.svh"
module mru_regs #(
  parameter logic [3:0] DENSITY_CODE = `MRU_DENS_8GB,
  parameter logic [1:0] WIDTH_CODE   = 2'h0,
  parameter logic [1:0] TYPE_CODE    = 2'h0,
  parameter int         NUM_BANKS    = 8,
  parameter int         ROW_BITS     = 15
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire mru_pkg::mru_req_s   req,
  input  wire logic                cal_ref_to_supply,
  input  wire logic [ROW_BITS-1:0] refresh_row,
  input  wire logic [2:0]          refresh_bank,
  output mru_pkg::mru_rsp_s        rsp,
  output logic                     cal_start,
  output mru_pkg::mru_cal_e        cal_op,
  output logic                     cal_resistor_present,
  output logic [7:0]               bank_mask,
  output logic [7:0]               segment_mask,
  output logic                     refresh_allowed,
  output logic                     device_reset
);

  // strap pin from outside: two stages before use
  logic       strap_meta_q;
  logic       strap_sync_q;
  logic [7:0] bank_mask_q;
  logic [7:0] seg_mask_q;
  logic       cal_start_q;
  mru_pkg::mru_cal_e cal_op_q;
  logic       resistor_q;
  logic       reset_q;
  mru_pkg::mru_rsp_s rsp_q;
  logic       wr;
  logic       rd;
  logic [2:0] seg_idx;
  logic       seg_supported;
  logic [7:0] info_byte;

  function automatic mru_pkg::mru_cal_e decode_cal(input logic [7:0] code);
    case (code)
      `MRU_CAL_INIT:    decode_cal = mru_pkg::MRU_CAL_INIT_OP;
      `MRU_CAL_LONG:    decode_cal = mru_pkg::MRU_CAL_LONG_OP;
      `MRU_CAL_SHORT:   decode_cal = mru_pkg::MRU_CAL_SHORT_OP;
      `MRU_CAL_DEFAULT: decode_cal = mru_pkg::MRU_CAL_DEF_OP;
      default:          decode_cal = mru_pkg::MRU_CAL_NONE;
    endcase
  endfunction

  assign wr = req.valid && req.write;
  assign rd = req.valid && !req.write;
  assign info_byte = {WIDTH_CODE, DENSITY_CODE, TYPE_CODE};

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strap_meta_q <= 1'b0;
      strap_sync_q <= 1'b0;
    end else begin
      strap_meta_q <= cal_ref_to_supply;
      strap_sync_q <= strap_meta_q;
    end
  end

  // calibration command decode; pulse lasts one cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cal_start_q <= 1'b0;
      cal_op_q    <= mru_pkg::MRU_CAL_NONE;
    end else begin
      cal_start_q <= 1'b0;
      cal_op_q    <= mru_pkg::MRU_CAL_NONE;
      if (wr && req.addr == `MRU_ADDR_CAL_CMD) begin
        if (decode_cal(req.data) == mru_pkg::MRU_CAL_NONE) begin
          cal_start_q <= 1'b0;
        end else if (strap_sync_q) begin
          // supply-tied: only default calibration is ever in effect
          cal_start_q <= 1'b0;
        end else begin
          cal_start_q <= 1'b1;
          cal_op_q    <= decode_cal(req.data);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      resistor_q <= 1'b0;
    end else if (wr && req.addr == `MRU_ADDR_CAL_CMD && req.data == `MRU_CAL_INIT) begin
      resistor_q <= !strap_sync_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bank_mask_q <= `MRU_MASK_RESET;
    end else if (wr && req.addr == `MRU_ADDR_BANK_MASK) begin
      bank_mask_q <= req.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      seg_mask_q <= `MRU_MASK_RESET;
    end else if (wr && req.addr == `MRU_ADDR_SEG_MASK) begin
      seg_mask_q <= req.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reset_q <= 1'b0;
    end else begin
      reset_q <= wr && req.addr == `MRU_ADDR_DEV_RESET;
    end
  end

  // read path; reserved and write-only addresses read back zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= '0;
      if (rd) begin
        rsp_q.valid <= 1'b1;
        case (req.addr)
          `MRU_ADDR_DEVICE_INFO: rsp_q.data <= info_byte;
          `MRU_ADDR_PATTERN_A: begin
            rsp_q.is_pattern <= 1'b1;
            rsp_q.pattern    <= `MRU_PATTERN_A_DEF;
          end
          `MRU_ADDR_PATTERN_B: begin
            rsp_q.is_pattern <= 1'b1;
            rsp_q.pattern    <= `MRU_PATTERN_B_DEF;
          end
          // test mode and 0Bh-0Fh carry no user function
          `MRU_ADDR_TEST_MODE: rsp_q.data <= 8'h00;
          default:             rsp_q.data <= 8'h00;
        endcase
      end
    end
  end

  // segment is the top three row bits of the array in use
  assign seg_idx       = refresh_row[ROW_BITS-1 -: 3];
  assign seg_supported = DENSITY_CODE >= `MRU_DENS_1GB && DENSITY_CODE <= `MRU_DENS_8GB;

  // four-bank parts ignore the upper mask bits
  always_comb begin
    refresh_allowed = 1'b1;
    if (NUM_BANKS == 4) begin
      if (bank_mask_q[refresh_bank[1:0]]) begin
        refresh_allowed = 1'b0;
      end
    end else if (bank_mask_q[refresh_bank]) begin
      refresh_allowed = 1'b0;
    end
    if (seg_supported && seg_mask_q[seg_idx]) begin
      refresh_allowed = 1'b0;
    end
  end

  assign rsp                  = rsp_q;
  assign cal_start            = cal_start_q;
  assign cal_op               = cal_op_q;
  assign cal_resistor_present = resistor_q;
  assign bank_mask            = bank_mask_q;
  assign segment_mask         = seg_supported ? seg_mask_q : 8'h00;
  assign device_reset         = reset_q;

endmodule

/* File: rtl/mru_params.svh */
`ifndef MRU_PARAMS_SVH
`define MRU_PARAMS_SVH
`define MRU_ADDR_DEVICE_INFO   8'h08
`define MRU_ADDR_TEST_MODE     8'h09
`define MRU_ADDR_CAL_CMD       8'h0A
`define MRU_ADDR_RSVD_LO_FIRST 8'h0B
`define MRU_ADDR_RSVD_LO_LAST  8'h0F
`define MRU_ADDR_BANK_MASK     8'h10
`define MRU_ADDR_SEG_MASK      8'h11
`define MRU_ADDR_PATTERN_A     8'h20
`define MRU_ADDR_PATTERN_B     8'h28
`define MRU_ADDR_DEV_RESET     8'h3F
`define MRU_CAL_INIT           8'hFF
`define MRU_CAL_LONG           8'hAB
`define MRU_CAL_SHORT          8'h56
`define MRU_CAL_DEFAULT        8'hC3
`define MRU_MASK_RESET         8'h00
`define MRU_DENS_LSB           2
`define MRU_DENS_MSB           5
`define MRU_WIDTH_LSB          6
`define MRU_WIDTH_MSB          7
`define MRU_DENS_1GB           4'h4
`define MRU_DENS_8GB           4'h7
`define MRU_PATTERN_A_DEF      32'h0000_0000
`define MRU_PATTERN_B_DEF      32'h0000_0000
`endif

/* File: rtl/mru_pkg.sv */
package mru_pkg;
  typedef enum logic [2:0] {
    MRU_CAL_NONE    = 3'h0,
    MRU_CAL_INIT_OP = 3'h1,
    MRU_CAL_LONG_OP = 3'h2,
    MRU_CAL_SHORT_OP= 3'h3,
    MRU_CAL_DEF_OP  = 3'h4
  } mru_cal_e;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } mru_req_s;
  typedef struct packed {
    logic        valid;
    logic        is_pattern;
    logic [7:0]  data;
    logic [31:0] pattern;
  } mru_rsp_s;
endpackage

/* File: dv/mru_regs_assertions.sv */
`timescale 1ns/1ps
module mru_regs_assertions (
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire mru_pkg::mru_req_s req,
  input wire logic              cal_ref_to_supply,
  input wire logic [2:0]        refresh_bank,
  input wire mru_pkg::mru_rsp_s rsp,
  input wire logic              cal_start,
  input wire mru_pkg::mru_cal_e cal_op,
  input wire logic [7:0]        bank_mask,
  input wire logic              refresh_allowed,
  input wire logic              device_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire wr = req.valid && req.write;
  wire rd = req.valid && !req.write;
  // strap must be steady through both sync stages
  chk_cal_long:
    assert property (!cal_ref_to_supply[*3] ##0 wr && req.addr == 8'h0A && req.data == 8'hAB
      |=> cal_start && cal_op == mru_pkg::MRU_CAL_LONG_OP) else $error("long cal missed");
  chk_cal_rsvd:
    assert property (wr && req.addr == 8'h0A && !(req.data inside {8'hFF, 8'hAB, 8'h56, 8'hC3}) |=> !cal_start)
      else $error("reserved cal acted");
  chk_cal_strap:
    assert property (cal_ref_to_supply[*3] ##0 wr && req.addr == 8'h0A && req.data != 8'hFF |=> !cal_start)
      else $error("cal with strap high");
  chk_bank_wr:
    assert property (wr && req.addr == 8'h10 |=> bank_mask == $past(req.data)) else $error("bank mask");
  chk_bank_hold:
    assert property (!(wr && req.addr == 8'h10) |=> $stable(bank_mask)) else $error("bank mask moved");
  chk_bank_block:
    assert property (bank_mask[refresh_bank] |-> !refresh_allowed) else $error("masked bank refreshed");
  chk_info_rd:
    assert property (rd && req.addr == 8'h08 |=> rsp.valid && rsp.data[7:2] == 6'h07) else $error("info");
  chk_pat_rd:
    assert property (rd && req.addr == 8'h28 |=> rsp.valid && rsp.is_pattern) else $error("pattern");
  chk_dev_reset:
    assert property (wr && req.addr == 8'h3F |=> device_reset) else $error("no reset");
endmodule

/* File: dv/mru_ctrl_model.sv */
`timescale 1ns/1ps
module mru_ctrl_model (
  input wire logic   core_clk,
  output mru_pkg::mru_req_s req
);
  initial req = '0;
  // idle bus carries inverted leftovers so nothing stale looks valid
  task automatic send(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req <= '{1'b1, w, a, d};
    @(negedge core_clk);
    req <= '{1'b0, ~w, ~a, ~d};
  endtask
endmodule

/* File: dv/sdram_mode_register_upper_bank_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; $display("Error %0t %h %h", $time, g, e); end end
module sdram_mode_register_upper_bank_tb;
  logic              core_clk = 0, rstn = 0, cal_ref_to_supply = 0;
  logic [14:0]       refresh_row = '0;
  logic [2:0]        refresh_bank = '0;
  int                fails = 0, total_checks = 0;
  mru_pkg::mru_req_s req;
  mru_pkg::mru_rsp_s rsp;
  mru_pkg::mru_cal_e cal_op;
  logic              cal_start, cal_resistor_present, refresh_allowed, device_reset;
  logic [7:0]        bank_mask, segment_mask;
  always #50 core_clk = ~core_clk;
  mru_ctrl_model u_ctrl (.core_clk, .req);
  mru_regs u_dut (.core_clk, .rstn, .req, .cal_ref_to_supply, .refresh_row, .refresh_bank, .rsp, .cal_start,
    .cal_op, .cal_resistor_present, .bank_mask, .segment_mask, .refresh_allowed, .device_reset);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ctrl.send(1'b1, a, d);
  endtask
  task automatic cal(input logic [7:0] d, input logic s, input mru_pkg::mru_cal_e e);
    wr(8'h0A, d);
    `CHK({cal_start, cal_op}, {s, e})
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic p);
    u_ctrl.send(1'b0, a, 8'h00);
    `CHK({rsp.valid, rsp.is_pattern, rsp.data, p ? rsp.pattern : 32'h0}, {1'b1, p, d, 32'h0})
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    rstn = 1;
    `CHK({bank_mask, segment_mask}, 16'h0000)
    cal(8'hFF, 1'b1, mru_pkg::MRU_CAL_INIT_OP);
    `CHK(cal_resistor_present, 1'b1)
    cal(8'hAB, 1'b1, mru_pkg::MRU_CAL_LONG_OP);
    cal(8'h56, 1'b1, mru_pkg::MRU_CAL_SHORT_OP);
    cal(8'hC3, 1'b1, mru_pkg::MRU_CAL_DEF_OP);
    cal(8'hAA, 1'b0, mru_pkg::MRU_CAL_NONE);
    cal_ref_to_supply = 1;
    repeat (3) @(negedge core_clk);
    cal(8'hAB, 1'b0, mru_pkg::MRU_CAL_NONE);
    cal(8'hFF, 1'b0, mru_pkg::MRU_CAL_NONE);
    `CHK(cal_resistor_present, 1'b0)
    cal_ref_to_supply = 0;
    wr(8'h10, 8'hA5);
    for (int b = 0; b < 8; b++) begin
      refresh_bank = b[2:0];
      #1 `CHK(refresh_allowed, 1'((8'h5A >> b) & 8'h01))
    end
    `CHK(bank_mask, 8'hA5)
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h81);
    refresh_row = 15'h7000;
    #1 `CHK({segment_mask, refresh_allowed}, {8'h81, 1'b0})
    refresh_row = 15'h1FFF;
    #1 `CHK(refresh_allowed, 1'b1)
    for (int i = 0; i < 4; i++) wr(i[1] ? (i[0] ? 8'h0F : 8'h0B) : (i[0] ? 8'h09 : 8'h08), 8'hFF);
    `CHK({bank_mask, segment_mask}, 16'h0081)
    rd(8'h08, 8'h1C, 1'b0);
    rd(8'h0B, 8'h00, 1'b0);
    rd(8'h20, 8'h00, 1'b1);
    rd(8'h28, 8'h00, 1'b1);
    wr(8'h3F, 8'h5A);
    `CHK(device_reset, 1'b1)
    wr(8'h3E, 8'h00);
    `CHK(device_reset, 1'b0)
    give_verdict();
  end
endmodule
bind mru_regs mru_regs_assertions u_chk (.core_clk, .rstn, .req, .cal_ref_to_supply, .refresh_bank, .rsp,
  .cal_start, .cal_op, .bank_mask, .refresh_allowed, .device_reset);
